/* verilog/dsr_defs.vh */
// register offsets, field positions, codes and timing values in ns for the sine/reset/fault block
`ifndef DSR_DEFS_VH
`define DSR_DEFS_VH
// register addresses (7-bit)
`define DSR_ADDR_FUNC0 7'h00
`define DSR_ADDR_FUNC1 7'h01
`define DSR_ADDR_CCFG 7'h02
`define DSR_ADDR_TRIG 7'h03
`define DSR_ADDR_STAT 7'h04
`define DSR_ADDR_GPIO 7'h05
`define DSR_ADDR_NVMW 7'h06
// channel waveform cfg fields
`define DSR_WSEL_LSB 0
`define DSR_WSEL_MSB 2
`define DSR_PHASE_LSB 3
`define DSR_PHASE_MSB 4
`define DSR_SLEW_LSB 5
`define DSR_SLEW_MSB 8
`define DSR_WSEL_SINE 3'h4
// common config fields
`define DSR_CCFG_LOCK 14
`define DSR_CCFG_REF 13
`define DSR_CCFG_IPDN0 2
`define DSR_CCFG_IPDN1 5
`define DSR_CCFG_VPDN0_LSB 0
`define DSR_CCFG_VPDN1_LSB 3
// trigger fields
`define DSR_TRIG_RST_LSB 0
`define DSR_TRIG_UNL_LSB 4
`define DSR_CODE_SWRST 4'ha
`define DSR_CODE_UNLOCK 4'h5
// gpio config fields
`define DSR_GPIO_RST_EN 0
`define DSR_GPIO_PDN_LSB 1
// status bits
`define DSR_STAT_USER 1
`define DSR_STAT_INT 0
`define DSR_STAT_BUSY 2
// reset values
`define DSR_FUNC_RST 16'h0000
`define DSR_CCFG_RST 16'h003f
`define DSR_GPIO_RST 16'h0000
// timing and crc constants
`define DSR_BOOT_NS 100000
`define DSR_SLEW_UNIT_NS 1000
`define DSR_CRC_POLY 16'h1021
`define DSR_CRC_INIT 16'hffff
`endif

/* verilog/dsr_ctrl.v */
// sine generator, reset sequencing, register lock and nvm check control of a two-channel dac
//
// Contract
// - sine advances one point per slew interval
// - waveform code 100 selects sine
// - fixed 24-entry 12-bit sine table
// - four selectable starting phases per channel
// - por loads nvm, access after boot
// - reset code 1010 acts as por
// - gpio reset boots on falling edge
// - lock bit rejects all register writes except to the trigger register
// - software reset passes lock
// - unlock code 0101 bypasses the lock
// - crc-16-ccitt stored and checked at start
// - alarm bits update only at boot
// - user crc fail sets alarm, factory values
// - internal crc fail sets alarm, factory values
// - alarms clear only by reset, reloads nvm
// - reference and outputs power independently
// - power-down field decoding per channel
// - powered-down current output is high impedance
// - power-up state from nvm, gpio mapping
`timescale 1ns/100ps
`include "dsr_defs.vh"

module dsr_ctrl #(
  parameter CLK_NS = 10,
  parameter BOOT_CYCLES = (`DSR_BOOT_NS + CLK_NS - 1) / CLK_NS,
  parameter SLEW_UNIT = (`DSR_SLEW_UNIT_NS + CLK_NS - 1) / CLK_NS,
  parameter NVM_WORDS = 4
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // nvm interface: image words and stored crc, read at boot
  input wire [16*NVM_WORDS-1:0] user_nvm_image,
  input wire [15:0] user_nvm_crc,
  input wire [15:0] int_nvm_image,
  input wire [15:0] int_nvm_crc,
  // nvm program request: crc of current settings to be stored
  output reg nvm_prog,
  output reg [15:0] nvm_prog_crc,
  // gpio pin from outside
  input wire gpio_in,
  // channel outputs, reference enable and boot status
  output reg [11:0] sine_code0,
  output reg [11:0] sine_code1,
  output reg sine_step0,
  output reg sine_step1,
  output reg [1:0] voltage_out_powerdown0,
  output reg [1:0] voltage_out_powerdown1,
  output reg current_out_en0,
  output reg current_out_en1,
  output reg int_ref_en,
  output reg booting
);

  ////////////////////////////////////////////////////////////////////////////
  // state and registers
  localparam ST_BOOT = 3'b001;
  localparam ST_CHECK = 3'b010;
  localparam ST_RUN = 3'b100;

  reg [2:0] state; // one-hot sequencer
  reg [31:0] boot_cnt; // boot delay counter
  reg [15:0] channel_waveform_cfg0; // channel 0 function settings
  reg [15:0] channel_waveform_cfg1; // channel 1 function settings
  reg [15:0] common_cfg; // lock, reference and power-down fields
  reg [15:0] gpio_cfg; // gpio function select
  reg user_store_check_alarm; // sticky until next boot
  reg internal_store_check_alarm; // sticky until next boot
  reg [2:0] gpio_sync; // three-stage synchroniser
  reg gpio_level; // debounced level after stage agreement
  reg sw_reset; // one-cycle reset request from trigger write
  reg unlock; // lock bypass latched by unlock code
  reg [4:0] idx0; // sine index channel 0
  reg [4:0] idx1; // sine index channel 1
  reg [31:0] slew_cnt0; // slew interval counter channel 0
  reg [31:0] slew_cnt1; // slew interval counter channel 1

  wire write_ok; // write passes the lock
  wire trig_wr; // write to trigger register
  wire gpio_fall; // filtered falling edge of gpio
  wire restart; // software or gpio reset request
  wire [15:0] user_crc; // computed crc of user image
  wire [15:0] int_crc; // computed crc of internal image
  wire [15:0] live_crc; // crc over current settings for programming

  ////////////////////////////////////////////////////////////////////////////
  // crc-16-ccitt over a word array, msb first
  function [15:0] crc_word;
    input [15:0] crc_in;
    input [15:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc_in;
      for (i = 15; i >= 0; i = i - 1)
      begin
        if (c[15] ^ data[i])
          c = {c[14:0], 1'b0} ^ `DSR_CRC_POLY;
        else
          c = {c[14:0], 1'b0};
      end
      crc_word = c;
    end
  endfunction

  function [15:0] crc_image;
    input [16*NVM_WORDS-1:0] img;
    integer k;
    reg [15:0] c;
    begin
      c = `DSR_CRC_INIT;
      for (k = 0; k < NVM_WORDS; k = k + 1)
        c = crc_word(c, img[16*k +: 16]);
      crc_image = c;
    end
  endfunction

  // fixed sine table, first quarter mirrored
  function [11:0] sine_lut;
    input [4:0] n;
    begin
      case (n)
        5'h00, 5'h0c: sine_lut = 12'h800;
        5'h01, 5'h0b: sine_lut = 12'h9a8;
        5'h02, 5'h0a: sine_lut = 12'hb33;
        5'h03, 5'h09: sine_lut = 12'hc87;
        5'h04, 5'h08: sine_lut = 12'hd8b;
        5'h05, 5'h07: sine_lut = 12'he2f;
        5'h06: sine_lut = 12'he66;
        5'h0d, 5'h17: sine_lut = 12'h658;
        5'h0e, 5'h16: sine_lut = 12'h4cd;
        5'h0f, 5'h15: sine_lut = 12'h379;
        5'h10, 5'h14: sine_lut = 12'h275;
        5'h11, 5'h13: sine_lut = 12'h1d1;
        5'h12: sine_lut = 12'h19a;
        default: sine_lut = 12'h800;
      endcase
    end
  endfunction

  // phase selects a quarter-period starting point
  function [4:0] phase_start;
    input [1:0] ph;
    begin
      phase_start = {1'b0, ph, 2'b00} + {2'b00, ph, 1'b0};
    end
  endfunction // ph*6: 0, 6, 12, 18

  assign user_crc = crc_image(user_nvm_image);
  assign int_crc = crc_word(`DSR_CRC_INIT, int_nvm_image);
  // same word order as the stored image (func0 lowest), so a reload checks clean
  assign live_crc = crc_image({gpio_cfg, common_cfg,
                               channel_waveform_cfg1, channel_waveform_cfg0});

  ////////////////////////////////////////////////////////////////////////////
  // gpio synchroniser and edge filter
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gpio_sync <= 3'h7;
      gpio_level <= 1'b1;
    end
    else
    begin
      gpio_sync <= {gpio_sync[1:0], gpio_in};
      if (gpio_sync[1] == gpio_sync[2])
        gpio_level <= gpio_sync[2];
    end
  end

  // only the falling edge counts; the rise does nothing
  assign gpio_fall = gpio_cfg[`DSR_GPIO_RST_EN] && gpio_level &&
                     (gpio_sync[1] == gpio_sync[2]) && !gpio_sync[2];

  // writes pass while unlocked or bypassed by the unlock code
  assign write_ok = state[2] && reg_wr &&
                    (!common_cfg[`DSR_CCFG_LOCK] || unlock);
  // the trigger register stays writable for reset even when locked
  assign trig_wr = state[2] && reg_wr && reg_addr == `DSR_ADDR_TRIG;
  assign restart = sw_reset || gpio_fall;

  ////////////////////////////////////////////////////////////////////////////
  // boot sequencer, nvm load, crc check and register file
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= ST_BOOT;
      boot_cnt <= 32'h0;
      channel_waveform_cfg0 <= `DSR_FUNC_RST;
      channel_waveform_cfg1 <= `DSR_FUNC_RST;
      common_cfg <= `DSR_CCFG_RST;
      gpio_cfg <= `DSR_GPIO_RST;
      user_store_check_alarm <= 1'b0;
      internal_store_check_alarm <= 1'b0;
      sw_reset <= 1'b0;
      unlock <= 1'b0;
      nvm_prog <= 1'b0;
      nvm_prog_crc <= 16'h0;
    end
    else
    begin
      sw_reset <= 1'b0;
      nvm_prog <= 1'b0;
      if (restart)
      begin
        // a reset event reruns the whole power-on sequence
        state <= ST_BOOT;
        boot_cnt <= 32'h0;
        unlock <= 1'b0;
      end
      else
      begin
        case (state)
          ST_BOOT:
          begin
            // hold off the host until the boot delay ends
            if (boot_cnt >= BOOT_CYCLES - 1)
              state <= ST_CHECK;
            else
              boot_cnt <= boot_cnt + 32'h1;
          end
          ST_CHECK:
          begin
            // alarms only change here, after the nvm image is read
            user_store_check_alarm <= (user_crc != user_nvm_crc);
            internal_store_check_alarm <= (int_crc != int_nvm_crc);
            if (user_crc != user_nvm_crc || int_crc != int_nvm_crc)
            begin
              // corrupt image: factory values, registers stay usable
              channel_waveform_cfg0 <= `DSR_FUNC_RST;
              channel_waveform_cfg1 <= `DSR_FUNC_RST;
              common_cfg <= `DSR_CCFG_RST;
              gpio_cfg <= `DSR_GPIO_RST;
            end
            else
            begin
              // good image: power-up state comes from nvm
              channel_waveform_cfg0 <= user_nvm_image[15:0];
              channel_waveform_cfg1 <= user_nvm_image[31:16];
              common_cfg <= user_nvm_image[47:32];
              gpio_cfg <= user_nvm_image[63:48];
            end
            state <= ST_RUN;
          end
          ST_RUN:
          begin
            if (trig_wr)
            begin
              if (reg_wdata[`DSR_TRIG_RST_LSB +: 4] == `DSR_CODE_SWRST)
                sw_reset <= 1'b1;
              if (reg_wdata[`DSR_TRIG_UNL_LSB +: 4] == `DSR_CODE_UNLOCK)
                unlock <= 1'b1;
            end
            if (write_ok)
            begin
              case (reg_addr)
                `DSR_ADDR_FUNC0: channel_waveform_cfg0 <= reg_wdata;
                `DSR_ADDR_FUNC1: channel_waveform_cfg1 <= reg_wdata;
                `DSR_ADDR_CCFG: common_cfg <= reg_wdata;
                `DSR_ADDR_GPIO: gpio_cfg <= reg_wdata;
                `DSR_ADDR_NVMW:
                begin
                  // program stores a fresh checksum beside the data
                  nvm_prog <= 1'b1;
                  nvm_prog_crc <= live_crc;
                end
                default: ;
              endcase
            end
          end
          default: state <= ST_BOOT;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sine generators, one per channel
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      idx0 <= 5'h0;
      idx1 <= 5'h0;
      slew_cnt0 <= 32'h0;
      slew_cnt1 <= 32'h0;
      sine_step0 <= 1'b0;
      sine_step1 <= 1'b0;
      sine_code0 <= 12'h800;
      sine_code1 <= 12'h800;
    end
    else
    begin
      sine_step0 <= 1'b0;
      sine_step1 <= 1'b0;
      // booting lags run by one cycle, so the first run cycle still parks on
      // the phase just loaded at check rather than on the pre-reset one
      if (!state[2] || booting ||
          channel_waveform_cfg0[`DSR_WSEL_MSB:`DSR_WSEL_LSB] != `DSR_WSEL_SINE)
      begin
        // idle or reset: park on the phase start point
        idx0 <= phase_start(channel_waveform_cfg0[`DSR_PHASE_MSB:`DSR_PHASE_LSB]);
        slew_cnt0 <= 32'h0;
      end
      else if (slew_cnt0 >= ({28'h0, channel_waveform_cfg0[`DSR_SLEW_MSB:`DSR_SLEW_LSB]}
                             + 32'h1) * SLEW_UNIT - 1)
      begin
        // one point per slew interval; 24 intervals per period
        slew_cnt0 <= 32'h0;
        sine_code0 <= sine_lut(idx0);
        sine_step0 <= 1'b1;
        idx0 <= (idx0 == 5'd23) ? 5'h0 : idx0 + 5'h1;
      end
      else
        slew_cnt0 <= slew_cnt0 + 32'h1;

      if (!state[2] || booting ||
          channel_waveform_cfg1[`DSR_WSEL_MSB:`DSR_WSEL_LSB] != `DSR_WSEL_SINE)
      begin
        idx1 <= phase_start(channel_waveform_cfg1[`DSR_PHASE_MSB:`DSR_PHASE_LSB]);
        slew_cnt1 <= 32'h0;
      end
      else if (slew_cnt1 >= ({28'h0, channel_waveform_cfg1[`DSR_SLEW_MSB:`DSR_SLEW_LSB]}
                             + 32'h1) * SLEW_UNIT - 1)
      begin
        slew_cnt1 <= 32'h0;
        sine_code1 <= sine_lut(idx1);
        sine_step1 <= 1'b1;
        idx1 <= (idx1 == 5'd23) ? 5'h0 : idx1 + 5'h1;
      end
      else
        slew_cnt1 <= slew_cnt1 + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down decode; gpio may force the mapped channels down
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      voltage_out_powerdown0 <= 2'h3;
      voltage_out_powerdown1 <= 2'h3;
      current_out_en0 <= 1'b0;
      current_out_en1 <= 1'b0;
      int_ref_en <= 1'b0;
      booting <= 1'b1;
    end
    else
    begin
      booting <= !state[2];
      int_ref_en <= state[2] && common_cfg[`DSR_CCFG_REF];
      // gpio low with mapping forces high impedance on that channel
      voltage_out_powerdown0 <= (!state[2] ||
        (gpio_cfg[`DSR_GPIO_PDN_LSB] && !gpio_level)) ? 2'h3 :
        common_cfg[`DSR_CCFG_VPDN0_LSB +: 2];
      voltage_out_powerdown1 <= (!state[2] ||
        (gpio_cfg[`DSR_GPIO_PDN_LSB + 1] && !gpio_level)) ? 2'h3 :
        common_cfg[`DSR_CCFG_VPDN1_LSB +: 2];
      // current output has no pull-down: off means high impedance
      current_out_en0 <= state[2] && !common_cfg[`DSR_CCFG_IPDN0] &&
        !(gpio_cfg[`DSR_GPIO_PDN_LSB] && !gpio_level);
      current_out_en1 <= state[2] && !common_cfg[`DSR_CCFG_IPDN1] &&
        !(gpio_cfg[`DSR_GPIO_PDN_LSB + 1] && !gpio_level);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0;
    else if (reg_rd)
    begin
      case (reg_addr)
        `DSR_ADDR_FUNC0: reg_rdata <= channel_waveform_cfg0;
        `DSR_ADDR_FUNC1: reg_rdata <= channel_waveform_cfg1;
        `DSR_ADDR_CCFG: reg_rdata <= common_cfg;
        `DSR_ADDR_STAT: reg_rdata <= {13'h0, booting, user_store_check_alarm,
                                      internal_store_check_alarm};
        `DSR_ADDR_GPIO: reg_rdata <= gpio_cfg;
        default: reg_rdata <= 16'h0; // trigger and unmapped read zero
      endcase
    end
    else
      reg_rdata <= 16'h0;
  end

endmodule // dsr_ctrl

/* verification/dsr_ctrl_monitor.sv */
// port-level assertion checker for the sine, reset, lock and nvm check control block
`timescale 1ns/100ps
module dsr_ctrl_monitor #(
  parameter BOOT_CYCLES = 10000
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // register port
  input wire [6:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_rdata,
  // observed pins and outputs
  input wire nvm_prog,
  input wire gpio_in,
  input wire [11:0] sine_code0,
  input wire sine_step0,
  input wire [1:0] voltage_out_powerdown0,
  input wire current_out_en0,
  input wire int_ref_en,
  input wire booting
);
  ////////////////////////////////////////////////////////////////////////////////
  // cycles spent booting, cleared whenever the block runs
  reg [15:0] boot_len;
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
      boot_len <= 16'h0;
    else
      boot_len <= booting ? boot_len + 16'h1 : 16'h0;

  // member of the fixed sine point set
  function automatic pt_ok(input [11:0] c);
    case (c)
      12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f, 12'he66,
      12'h658, 12'h4cd, 12'h379, 12'h275, 12'h1d1, 12'h19a: pt_ok = 1'b1;
      default: pt_ok = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  default clocking mon_cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_rst_state: assert property (
    $rose(rst_n) |-> booting && !int_ref_en && !current_out_en0 &&
      voltage_out_powerdown0 == 2'h3 && sine_code0 == 12'h800)
    else $error("outputs not in power-on state after reset");
  chk_read_idle: assert property (
    !$past(reg_rd) |-> reg_rdata == 16'h0)
    else $error("read data present without a read");
  chk_trig_read: assert property (
    reg_rd && reg_addr == 7'h03 |=> reg_rdata == 16'h0)
    else $error("trigger register read not zero");
  chk_sine_point: assert property (
    sine_step0 |-> pt_ok(sine_code0))
    else $error("sine code outside the point table");
  chk_step_gap: assert property (
    sine_step0 |=> !sine_step0)
    else $error("sine steps too close");
  chk_prog_pulse: assert property (
    nvm_prog |=> !nvm_prog)
    else $error("program request longer than one cycle");
  chk_swrst_boot: assert property (
    reg_wr && reg_addr == 7'h03 && reg_wdata[3:0] == 4'ha && !booting |-> ##[1:4] booting)
    else $error("software reset did not start boot");
  chk_boot_min: assert property (
    $fell(booting) |-> boot_len >= BOOT_CYCLES)
    else $error("boot ended early");
  chk_boot_max: assert property (
    booting |-> boot_len <= BOOT_CYCLES + 8)
    else $error("boot lasted too long");
  chk_gpio_rise: assert property (
    $rose(gpio_in) && !booting |=> !booting [*6])
    else $error("rising reset pin edge started boot");
endmodule // dsr_ctrl_monitor

bind dsr_ctrl dsr_ctrl_monitor #(.BOOT_CYCLES(BOOT_CYCLES)) mon_u (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .nvm_prog(nvm_prog), .gpio_in(gpio_in), .sine_code0(sine_code0),
  .sine_step0(sine_step0), .voltage_out_powerdown0(voltage_out_powerdown0),
  .current_out_en0(current_out_en0), .int_ref_en(int_ref_en), .booting(booting));

/* verification/dsr_ctrl_tb.sv */
// self-checking bench for the sine, reset, lock and nvm check control block
`timescale 1ns/100ps
module dsr_ctrl_tb;
  localparam BC = 20; // shortened boot count keeps runs brief
  localparam SU = 2; // shortened slew unit
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
  ////////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  reg clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, gpio = 1;
  reg [6:0] reg_addr = 0;
  reg [15:0] reg_wdata = 0, ucrc = 0, icrc = 0, iimg = 16'h5a3c, d;
  reg [63:0] img = 0;
  wire [15:0] reg_rdata, pcrc;
  wire [11:0] sc0, sc1;
  wire [1:0] vp0, vp1;
  wire st0, st1, prog, cen0, cen1, ref_en, booting;
  integer error_cnt = 0, cmp_count = 0, seed = 32'h382e, p, sl, i, n;
  // expected sine points
  int sine[24] = '{12'h800, 12'h9a8, 12'hb33, 12'hc87, 12'hd8b, 12'he2f, 12'he66, 12'he2f,
    12'hd8b, 12'hc87, 12'hb33, 12'h9a8, 12'h800, 12'h658, 12'h4cd, 12'h379, 12'h275,
    12'h1d1, 12'h19a, 12'h1d1, 12'h275, 12'h379, 12'h4cd, 12'h658};

  dsr_ctrl #(.BOOT_CYCLES(BC), .SLEW_UNIT(SU)) dut_u (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .user_nvm_image(img), .user_nvm_crc(ucrc),
    .int_nvm_image(iimg), .int_nvm_crc(icrc), .nvm_prog(prog), .nvm_prog_crc(pcrc),
    .gpio_in(gpio), .sine_code0(sc0), .sine_code1(sc1), .sine_step0(st0),
    .sine_step1(st1), .voltage_out_powerdown0(vp0), .voltage_out_powerdown1(vp1),
    .current_out_en0(cen0), .current_out_en1(cen1), .int_ref_en(ref_en), .booting(booting));

  // 100 MHz clock
  initial
  begin
    forever #5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reference crc, words low first, bits msb first
  function [15:0] crc16(input [63:0] v, input integer nw);
    integer k;
    reg b;
    begin
      crc16 = 16'hffff;
      for (k = 0; k < 16 * nw; k++)
      begin
        b = v[16 * (k / 16) + 15 - k % 16] ^ crc16[15];
        crc16 = {crc16[14:0], 1'b0} ^ (b ? 16'h1021 : 16'h0000);
      end
    end
  endfunction

  // sine-mode waveform word: slew, phase, select code
  function [15:0] fw(input integer ph, input integer s);
    fw = {7'h0, s[3:0], ph[1:0], 3'h4};
  endfunction

  // load the user store with a matching checksum
  task ld(input [63:0] v);
    img <= v;
    ucrc <= crc16(v, 4);
  endtask

  // one-cycle register write
  task wr(input [6:0] a, input [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // one-cycle read, data checked in the following cycle only
  task rd(input [6:0] a, input [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask

  // bounded wait for boot to finish
  task boot;
    i = 0;
    while (booting !== 1'b0 && i < 200)
    begin
      @(posedge clk);
      #1 i++;
    end
    `CHK(booting, 1'b0)
  endtask

  // power-on reset pulse
  task por;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    boot;
  endtask

  // software reset: boot must be under way three edges later
  task swrst;
    wr(7'h03, 16'h000a);
    repeat (3) @(posedge clk);
    #1 `CHK(booting, 1'b1)
    boot;
  endtask

  // follow 25 sine points, checking codes, wrap and spacing
  task chk_sine(input integer ch, input integer st, input integer s);
    integer k, g, x;
    reg [11:0] c;
    begin
      x = st;
      for (k = 0; k < 25; k++)
      begin
        g = 0;
        do
        begin
          @(posedge clk);
          #1 g++;
        end while ((ch ? st1 : st0) !== 1'b1 && g < 100);
        c = ch ? sc1 : sc0;
        // the very first step must show the phase start point itself
        if (k > 0) x = (x + 1) % 24;
        `CHK(c, sine[x][11:0])
        if (k > 0) `CHK(g, (s + 1) * SU)
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    icrc = crc16({48'h0, iimg}, 1);
    repeat (12) @(posedge clk);
    #1 `CHK({booting, ref_en, cen0, cen1, vp0, vp1}, 8'h8f)
    // every phase, restarted by power-on or software reset
    for (p = 0; p < 4; p++)
    begin
      sl = $random(seed) & 3;
      ld({16'h0000, 16'h2031, fw(p, sl), fw(p, sl)});
      if (p == 2) swrst; else por;
      chk_sine(p % 2, 6 * p, sl);
    end
    rd(7'h02, 16'h2031);
    rd(7'h04, 16'h0000);
    `CHK({ref_en, cen0, cen1, vp0, vp1}, 7'h66)
    $display("phase and load test done");
    // lock, software reset through lock, unlock bypass
    d = $random(seed);
    wr(7'h02, 16'h6031);
    wr(7'h01, d);
    rd(7'h01, fw(3, sl));
    swrst;
    rd(7'h02, 16'h2031);
    wr(7'h02, 16'h6031);
    wr(7'h03, 16'h0050);
    wr(7'h01, d);
    rd(7'h01, d);
    rd(7'h03, 16'h0000);
    $display("lock test done");
    // checksum alarms
    ucrc <= ucrc ^ 16'h0001;
    por;
    rd(7'h04, 16'h0002);
    rd(7'h02, 16'h003f);
    `CHK({ref_en, cen0, cen1, vp0, vp1}, 7'h0f)
    n = 0;
    repeat (40) @(posedge clk) n = n + st0;
    `CHK(n, 0)
    wr(7'h00, d);
    rd(7'h00, d);
    ucrc <= ucrc ^ 16'h0001;
    icrc <= icrc ^ 16'h0001;
    rd(7'h04, 16'h0002);
    swrst;
    rd(7'h04, 16'h0001);
    icrc <= icrc ^ 16'h0001;
    swrst;
    rd(7'h04, 16'h0000);
    $display("checksum test done");
    // program request carries the checksum of the live settings
    wr(7'h06, 16'h0000);
    #1 i = 0;
    while (prog !== 1'b1 && i < 10)
    begin
      @(posedge clk);
      #1 i++;
    end
    `CHK(pcrc, crc16(img, 4))
    $display("program test done");
    // reset pin: falling edge boots, rising edge does nothing
    ld({16'h0001, 16'h2031, fw(0, sl), fw(0, sl)});
    por;
    @(posedge clk) gpio <= 1'b0;
    repeat (8) @(posedge clk);
    #1 `CHK(booting, 1'b1)
    // a program request while booting must be refused
    wr(7'h06, 16'h0000);
    #1 `CHK(prog, 1'b0)
    boot;
    @(posedge clk) gpio <= 1'b1;
    repeat (10) @(posedge clk);
    #1 `CHK(booting, 1'b0)
    $display("reset pin test done");
    complete_run;
  end

  // hang guard
  initial
  begin
    #800000;
    error_cnt++;
    complete_run;
  end

  // verdict and end of run
  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
endmodule // dsr_ctrl_tb
